/* File: hdl/ihb_core.sv */
// ihb_core: host serial clock generation and stop-condition
// collision detection with its register file.
// assumes: open-drain bus lines with external pull-ups; one clock.
//
// Functional notes
// R1 - stop: hold data low, release clock
// R2 - clock high: load generator, count, sample
// R3 - data low after expiry: collision
// R4 - clock low before data high: collision
// R5 - generator clocks both host modes
// R6 - data buffer write starts generator
// R7 - operation done: stop, hold clock level
// R8 - divider reloaded every half period
// R9 - period is four times divider plus one
// R10 - software avoids divider values below three
// R11 - ten-bit high byte: bits 2:1 give 9:8
// R12 - ten-bit low byte: all eight bits
// R13 - seven-bit: bits 7:1 address
// R14 - data buffer read/write, no reset value
// R15 - collision sets flag, port goes idle
// R16 - collision aborts stop, releases lines
// R17 - generator expiry paces stop sequence
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module ihb_core
	import ihb_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire ihb_req_t   bus_req,
	output logic [7:0]      bus_rdata,
	input  wire ihb_pins_t  pin_in,
	output ihb_pins_t       pin_out,
	output ihb_pins_t       pin_oe,
	output logic            sck,
	output logic [9:0]      client_addr,
	output logic            irq
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	ihb_pins_t  pin_s;
	logic       brg_load;
	logic       brg_run;
	logic       brg_to;

	logic [7:0] data_buffer;
	logic [7:0] baud_divider_or_address;
	logic [3:0] port_mode_select;
	logic       addr_hi_sel;
	logic [1:0] irq_en;
	logic [1:0] irq_stat;
	logic [7:0] next_data_buffer;
	logic [7:0] next_div;
	logic [3:0] next_mode;
	logic       next_hi_sel;
	logic [1:0] next_irq_en;
	logic [1:0] next_irq_stat;
	logic [1:0] irq_clr;
	logic [7:0] next_rdata;
	logic [9:0] next_client_addr;
	logic       next_irq;

	ihb_stop_t  stop_st;
	ihb_stop_t  next_stop_st;
	logic       stop_req;
	logic       next_stop_req;
	logic       clk_act;
	logic       next_clk_act;
	logic       clk_level;
	logic       next_clk_level;
	logic [4:0] half_cnt;
	logic [4:0] next_half_cnt;
	logic       scl_drv;
	logic       next_scl_drv;
	logic       sda_drv;
	logic       next_sda_drv;
	logic       next_sck;
	logic       coll_ev;
	logic       done_ev;
	logic       dbuf_wr;
	logic       ctrl_wr;
	logic       i2c_host;

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	// line levels reach the engine two cycles late; the stop states
	// wait on levels, never on edges, so the delay only stretches them
	ihb_sync u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.pin_in   (pin_in),
		.pin_sync (pin_s)
	);

	ihb_brg u_brg (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.load    (brg_load),
		.run     (brg_run),
		.reload  (baud_divider_or_address),
		.timeout (brg_to)
	);

	assign dbuf_wr  = bus_req.wr && ihb_hit(bus_req, OFS_DBUF);
	assign ctrl_wr  = bus_req.wr && ihb_hit(bus_req, OFS_CTRL);
	assign i2c_host = port_mode_select == MODE_I2C_HOST;

	// ----------------------------------------------------------------
	// generator control
	// ----------------------------------------------------------------
	// kept apart from the engine: the timeout depends on load and run,
	// so computing them beside its consumer would close a loop
	always_comb begin
		brg_run  = clk_act || stop_st == ST_SCL_HIGH || stop_st == ST_SDA_REL;
		brg_load = 1'b0;
		if (!clk_act && dbuf_wr && ihb_is_host(port_mode_select) &&
				stop_st == ST_IDLE) begin
			brg_load = 1'b1;                                 // [R6]
		end else if (stop_st == ST_SCL_REL && pin_s.scl) begin
			brg_load = 1'b1;                                 // [R2]
		end
	end

	// ----------------------------------------------------------------
	// engine: clock generation and stop sequence
	// ----------------------------------------------------------------
	always_comb begin
		next_stop_st   = stop_st;
		next_stop_req  = stop_req;
		next_clk_act   = clk_act;
		next_clk_level = clk_level;
		next_half_cnt  = half_cnt;
		next_scl_drv   = scl_drv;
		next_sda_drv   = sda_drv;
		coll_ev        = 1'b0;
		done_ev        = 1'b0;

		if (ctrl_wr && bus_req.wdata[CTRL_STOP_BIT]) begin
			next_stop_req = 1'b1;
		end

		// byte clocking in either host mode
		if (clk_act) begin
			if (brg_to) begin
				next_clk_level = !clk_level;
				next_half_cnt  = half_cnt + HALF_ONE;
				next_scl_drv   = i2c_host && clk_level;
				if (half_cnt == HALF_LAST) begin
					// clock pin keeps its last level
					next_clk_act = 1'b0;                      // [R7]
				end
			end
		end else if (dbuf_wr && ihb_is_host(port_mode_select) &&
				stop_st == ST_IDLE) begin
			// only an idle clock starts; a later write just stores data
			next_clk_act  = 1'b1;                            // [R5] [R6]
			next_half_cnt = HALF_ZERO;
		end

		unique case (stop_st)
			ST_IDLE: begin
				if (stop_req && i2c_host && !clk_act) begin
					next_sda_drv = 1'b1;                      // [R1]
					next_stop_st = ST_SDA_LOW;
				end
			end
			ST_SDA_LOW: begin
				// no time limit: a data line stuck high stalls the stop
				if (!pin_s.sda) begin
					next_scl_drv = 1'b0;                      // [R1]
					next_stop_st = ST_SCL_REL;
				end
			end
			ST_SCL_REL: begin
				// clock arbitration: wait for the line to rise
				if (pin_s.scl) begin
					next_stop_st = ST_SCL_HIGH;               // [R2]
				end
			end
			ST_SCL_HIGH: begin
				if (!pin_s.scl) begin
					coll_ev = 1'b1;                           // [R4]
				end else if (brg_to) begin
					next_sda_drv = 1'b0;                      // [R17]
					next_stop_st = ST_SDA_REL;
				end
			end
			ST_SDA_REL: begin
				// clock pulled low while data is still low: another host
				if (!pin_s.scl && !pin_s.sda) begin
					coll_ev = 1'b1;                           // [R4]
				end else if (brg_to) begin
					if (!pin_s.sda) begin
						coll_ev = 1'b1;                       // [R2] [R3]
					end else begin
						done_ev       = 1'b1;
						next_stop_req = 1'b0;
						next_stop_st  = ST_IDLE;
					end
				end
			end
			default: begin
				next_stop_st = ST_IDLE;
			end
		endcase

		// abort, release both lines, drop the stop request
		if (coll_ev) begin
			next_stop_st  = ST_IDLE;                         // [R15] [R16]
			next_stop_req = 1'b0;                            // [R16]
			next_scl_drv  = 1'b0;
			next_sda_drv  = 1'b0;
			next_clk_act  = 1'b0;
		end

		// outside spi host mode the pin keeps its level
		next_sck = (port_mode_select == MODE_SPI_HOST) ? next_clk_level : sck;
	end

	// open drain: the pads only ever pull low, so pin_out stays zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stop_st   <= ST_IDLE;
			stop_req  <= 1'b0;
			clk_act   <= 1'b0;
			clk_level <= 1'b0;
			half_cnt  <= HALF_ZERO;
			scl_drv   <= 1'b0;
			sda_drv   <= 1'b0;
			sck       <= 1'b0;
			pin_oe    <= '0;
			pin_out   <= '0;
		end else begin
			stop_st   <= next_stop_st;
			stop_req  <= next_stop_req;
			clk_act   <= next_clk_act;
			clk_level <= next_clk_level;
			half_cnt  <= next_half_cnt;
			scl_drv   <= next_scl_drv;
			sda_drv   <= next_sda_drv;
			sck       <= next_sck;
			pin_oe    <= '{scl: next_scl_drv, sda: next_sda_drv};
			pin_out   <= '0;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_comb begin
		next_data_buffer = data_buffer;
		next_div         = baud_divider_or_address;
		next_mode        = port_mode_select;
		next_hi_sel      = addr_hi_sel;
		next_irq_en      = irq_en;
		irq_clr          = IRQ_RST;
		next_rdata       = 8'h00;

		// unmapped writes fall through and change nothing
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				OFS_DBUF: next_data_buffer = bus_req.wdata;   // [R14]
				OFS_DIV:  next_div         = bus_req.wdata;
				OFS_CTRL: begin
					next_mode   = bus_req.wdata[CTRL_MODE_LSB +: 4];
					next_hi_sel = bus_req.wdata[CTRL_HI_BIT];
				end
				OFS_IEN:  next_irq_en = bus_req.wdata[1:0];
				OFS_ICLR: irq_clr     = bus_req.wdata[1:0];
				default:  ;
			endcase
		end

		// the clear register is write-only and reads as zero
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				OFS_DBUF: next_rdata = data_buffer;           // [R14]
				OFS_DIV:  next_rdata = baud_divider_or_address;
				OFS_CTRL: next_rdata = {2'h0, addr_hi_sel, stop_req,
						port_mode_select};
				OFS_STAT: next_rdata = {4'h0, clk_act,
						stop_st != ST_IDLE, irq_stat};
				OFS_IEN:  next_rdata = {6'h00, irq_en};
				default:  next_rdata = 8'h00;
			endcase
		end

		// a new event beats a clear in the same cycle
		next_irq_stat = irq_stat & ~irq_clr;
		if (coll_ev) begin
			next_irq_stat[EV_COLL] = 1'b1;                   // [R15]
		end
		if (done_ev) begin
			next_irq_stat[EV_DONE] = 1'b1;
		end
		next_irq = |(next_irq_stat & next_irq_en);

		// client address view of the shared register;
		// host modes leave the view untouched
		next_client_addr = client_addr;
		unique case (port_mode_select)
			MODE_I2C_CL10: begin
				if (addr_hi_sel) begin
					next_client_addr = {baud_divider_or_address[2:1],
						client_addr[7:0]};                    // [R11]
				end else begin
					next_client_addr = {client_addr[9:8],
						baud_divider_or_address};             // [R12]
				end
			end
			MODE_I2C_CL7: begin
				next_client_addr = {3'h0,
					baud_divider_or_address[7:1]};            // [R13]
			end
			default: ;
		endcase
	end

	// buffer contents carry no reset value
	always_ff @(posedge clk_sys) begin
		data_buffer <= next_data_buffer;                     // [R14]
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			baud_divider_or_address <= DIV_RST;
			port_mode_select        <= MODE_RST;
			addr_hi_sel             <= 1'b0;
			irq_en                  <= IRQ_RST;
			irq_stat                <= IRQ_RST;
			bus_rdata               <= 8'h00;
			client_addr             <= CADDR_RST;
			irq                     <= 1'b0;
		end else begin
			baud_divider_or_address <= next_div;
			port_mode_select        <= next_mode;
			addr_hi_sel             <= next_hi_sel;
			irq_en                  <= next_irq_en;
			irq_stat                <= next_irq_stat;
			bus_rdata               <= next_rdata;
			client_addr             <= next_client_addr;
			irq                     <= next_irq;
		end
	end
endmodule // ihb_core

/* File: hdl/ihb_pkg.sv */
// ihb_pkg: constants, types and helpers for the host baud generator
// and stop-collision block.
// assumes: single clock clk_sys, registers reached over a plain port.
package ihb_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int         ADDR_W    = 12;
	localparam logic [11:0] OFS_DBUF = 12'h78C;
	localparam logic [11:0] OFS_DIV  = 12'h78D;
	localparam logic [11:0] OFS_CTRL = 12'h7A0;
	localparam logic [11:0] OFS_STAT = 12'h7A1;
	localparam logic [11:0] OFS_IEN  = 12'h7A2;
	localparam logic [11:0] OFS_ICLR = 12'h7A3;

	localparam logic [7:0] DIV_RST   = 8'h00;
	localparam logic [3:0] MODE_RST  = 4'h0;
	localparam logic [1:0] IRQ_RST   = 2'h0;
	localparam logic [9:0] CADDR_RST = 10'h000;

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_STOP_BIT = 4;
	localparam int CTRL_HI_BIT   = 5;
	localparam int EV_COLL       = 0;
	localparam int EV_DONE       = 1;

	// port_mode_select encodings
	localparam logic [3:0] MODE_SPI_HOST = 4'hA;
	localparam logic [3:0] MODE_I2C_CL7  = 4'h6;
	localparam logic [3:0] MODE_I2C_CL10 = 4'h7;
	localparam logic [3:0] MODE_I2C_HOST = 4'h8;

	// sixteen half periods make one eight-bit transfer
	localparam logic [4:0] HALF_LAST = 5'h0F;
	localparam logic [4:0] HALF_ONE  = 5'h01;
	localparam logic [4:0] HALF_ZERO = 5'h00;
	localparam logic [7:0] CNT_ZERO  = 8'h00;
	localparam logic [7:0] CNT_ONE   = 8'h01;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} ihb_req_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} ihb_pins_t;

	typedef enum logic [4:0] {
		ST_IDLE     = 5'b00001,
		ST_SDA_LOW  = 5'b00010,
		ST_SCL_REL  = 5'b00100,
		ST_SCL_HIGH = 5'b01000,
		ST_SDA_REL  = 5'b10000
	} ihb_stop_t;

	function automatic logic ihb_is_host(input logic [3:0] mode);
		return (mode == MODE_I2C_HOST) || (mode == MODE_SPI_HOST);
	endfunction

	function automatic logic ihb_hit(input ihb_req_t r, input logic [11:0] ofs);
		return r.addr == ofs;
	endfunction

endpackage

/* File: hdl/ihb_sync.sv */
// ihb_sync: two-flop synchroniser for the bus line levels.
// assumes: inputs are asynchronous pins; only stage two is read.
`timescale 1ns/1ps
module ihb_sync
	import ihb_pkg::*;
(
	input  wire logic      clk_sys,
	input  wire logic      rst_n,
	input  wire ihb_pins_t pin_in,
	output ihb_pins_t      pin_sync
);
	ihb_pins_t stage1;
	ihb_pins_t next_stage1;
	ihb_pins_t next_sync;

	// idle bus reads high through pull-ups
	always_comb begin
		next_stage1 = pin_in;
		next_sync   = stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stage1   <= '1;
			pin_sync <= '1;
		end else begin
			stage1   <= next_stage1;
			pin_sync <= next_sync;
		end
	end
endmodule // ihb_sync

/* File: hdl/ihb_brg.sv */
// ihb_brg: reloadable down-counter baud generator.
// assumes: reload value is steady while run is high; load is a pulse.
`timescale 1ns/1ps
module ihb_brg
	import ihb_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic       run,
	input  wire logic [7:0] reload,
	output logic            timeout
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic       tick;
	logic       next_tick;

	// ----------------------------------------------------------------
	// counter decrements at half the system rate, so each expiry is
	// 2*(n+1) cycles and a full clock period 4*(n+1)
	// ----------------------------------------------------------------
	always_comb begin
		next_cnt  = cnt;
		next_tick = 1'b0;
		timeout   = 1'b0;
		if (load) begin
			next_cnt = reload;
		end else if (run) begin
			next_tick = !tick;
			if (tick) begin
				if (cnt == CNT_ZERO) begin
					timeout  = 1'b1;                          // [R17]
					next_cnt = reload;                        // [R8] [R9]
				end else begin
					next_cnt = cnt - CNT_ONE;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt  <= CNT_ZERO;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule // ihb_brg

/* File: bench/ihb_bus_model.sv */
// ihb_bus_model: open-drain bus lines with pull-ups and a second party.
// assumes: the bench commands the second party; lines settle at once.
`timescale 1ns/1ps
module ihb_bus_model
	import ihb_pkg::*;
(
	input  wire ihb_pins_t pin_oe,
	input  wire logic      hold_sda,
	input  wire logic      pull_scl,
	output ihb_pins_t      pin_in
);
	// wired-and: a released line floats high through its pull-up
	always_comb begin
		pin_in.sda = !pin_oe.sda && !hold_sda;
		pin_in.scl = !pin_oe.scl && !pull_scl;
	end
endmodule // ihb_bus_model

/* File: bench/ihb_chk.sv */
// ihb_chk: port-level checks for ihb_core.
// assumes: bound to ihb_core; one clock, synchronous reset.
`timescale 1ns/1ps
module ihb_chk
	import ihb_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire ihb_req_t   bus_req,
	input wire logic [7:0] bus_rdata,
	input wire ihb_pins_t  pin_in,
	input wire ihb_pins_t  pin_out,
	input wire ihb_pins_t  pin_oe,
	input wire logic       sck,
	input wire logic [9:0] client_addr,
	input wire logic       irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------
	// shadows rebuilt from bus writes
	// ------------------------------------------------
	logic [3:0] mode_sh;
	logic [7:0] div_sh;
	logic [7:0] buf_sh;
	logic [1:0] ien_sh;
	logic [9:0] gap;
	logic [4:0] tog;
	logic       hi_sh;
	logic       buf_ok;
	logic       sck_q;
	logic       seen;
	wire        wr_div = bus_req.wr && bus_req.addr == OFS_DIV;
	wire        wr_buf = bus_req.wr && bus_req.addr == OFS_DBUF;
	wire        wr_ctl = bus_req.wr && bus_req.addr == OFS_CTRL;
	wire        wr_ien = bus_req.wr && bus_req.addr == OFS_IEN;
	wire        tgl    = sck != sck_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_sh <= MODE_RST;
			hi_sh <= 1'b0;
			div_sh <= DIV_RST;
			buf_ok <= 1'b0;
			ien_sh <= IRQ_RST;
			sck_q <= 1'b0;
			seen <= 1'b0;
			tog <= 5'h00;
			gap <= 10'h000;
		end else begin
			mode_sh <= wr_ctl ? bus_req.wdata[3:0] : mode_sh;
			hi_sh <= wr_ctl ? bus_req.wdata[5] : hi_sh;
			div_sh <= wr_div ? bus_req.wdata : div_sh;
			buf_sh <= wr_buf ? bus_req.wdata : buf_sh;
			buf_ok <= buf_ok || wr_buf;
			ien_sh <= wr_ien ? bus_req.wdata[1:0] : ien_sh;
			sck_q <= sck;
			// first edge after a start has no reference point
			seen <= !wr_buf && (seen || tgl);
			tog <= wr_buf ? 5'h00 : tog + 5'(tgl);
			gap <= tgl ? 10'h001 : gap + 10'h001;
		end
	end
	property p_div_rd;
		$past(bus_req.rd && bus_req.addr == OFS_DIV) |-> bus_rdata == div_sh;
	endproperty
	a_div_rd: assert property (p_div_rd) else $error("divider readback");
	property p_buf_rd;
		buf_ok && $past(bus_req.rd && bus_req.addr == OFS_DBUF) |-> bus_rdata == buf_sh;
	endproperty
	a_buf_rd: assert property (p_buf_rd) else $error("buffer readback");
	property p_ca7;
		wr_div && mode_sh == MODE_I2C_CL7 |-> ##2 client_addr == {3'h0, div_sh[7:1]};
	endproperty
	a_ca7: assert property (p_ca7) else $error("seven-bit address");
	property p_ca10;
		wr_div && mode_sh == MODE_I2C_CL10
		|-> ##2 (hi_sh ? client_addr[9:8] == div_sh[2:1] : client_addr[7:0] == div_sh);
	endproperty
	a_ca10: assert property (p_ca10) else $error("ten-bit address");
	property p_half;
		tgl && seen |-> gap == {1'b0, div_sh, 1'b0} + 10'h002;
	endproperty
	a_half: assert property (p_half) else $error("half period");
	property p_tog;
		tog <= 5'h10;
	endproperty
	a_tog: assert property (p_tog) else $error("clock ran on");
	property p_sck_mode;
		mode_sh != MODE_SPI_HOST && $past(mode_sh, 2) != MODE_SPI_HOST |-> !sck;
	endproperty
	a_sck_mode: assert property (p_sck_mode) else $error("sck outside spi");
	property p_stop_go;
		wr_ctl && bus_req.wdata == 8'h18 && mode_sh == MODE_I2C_HOST && pin_oe == 2'b00
		|-> ##[1:3] pin_oe.sda;
	endproperty
	a_stop_go: assert property (p_stop_go) else $error("stop not begun");
	property p_sda_rel;
		$fell(pin_oe.sda) |-> !pin_oe.scl;
	endproperty
	a_sda_rel: assert property (p_sda_rel) else $error("sda freed early");
	property p_coll;
		$rose(irq) && ien_sh == 2'b01 |-> pin_oe == 2'b00;
	endproperty
	a_coll: assert property (p_coll) else $error("lines held");
	property p_pin_out;
		pin_out == 2'b00;
	endproperty
	a_pin_out: assert property (p_pin_out) else $error("pads driven high");
endmodule // ihb_chk

/* File: bench/tb.sv */
// tb: self-checking bench for ihb_core against a wired-and bus model.
// assumes: package, design, model and checker compiled first.
`timescale 1ns/1ps
module tb
	import ihb_pkg::*;
;
	logic       clk_sys  = 1'b0;
	logic       rst_n    = 1'b0;
	logic       hold_sda = 1'b0;
	logic       pull_scl = 1'b0;
	ihb_req_t   req      = '0;
	ihb_pins_t  pin_in;
	ihb_pins_t  pin_out;
	ihb_pins_t  pin_oe;
	logic [7:0] rdata;
	logic [7:0] d;
	logic [9:0] client_addr;
	logic       sck;
	logic       irq;
	logic       s;
	int         fail_count = 0;
	int         n_compared = 0;
	int         cyc        = 0;
	int         ca         = 0;
	int         n;
	int         t;
	int         q[$];
	logic [7:0] ien[3] = '{8'h03, 8'h01, 8'h02};
	logic [7:0] cm[3]  = '{8'h06, 8'h27, 8'h07};
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	ihb_core uut (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.bus_req    (req),
		.bus_rdata  (rdata),
		.pin_in     (pin_in),
		.pin_out    (pin_out),
		.pin_oe     (pin_oe),
		.sck        (sck),
		.client_addr(client_addr),
		.irq        (irq)
	);
	ihb_bus_model bus (
		.pin_oe  (pin_oe),
		.hold_sda(hold_sda),
		.pull_scl(pull_scl),
		.pin_in  (pin_in)
	);
	// ------------------------------------------------
	// bus cycles and comparison
	// ------------------------------------------------
	task automatic wrap_up();
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic timeout();
		fail_count++;
		$display("wrong value at %0t: wait ran out", $time);
		wrap_up();
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		@(negedge clk_sys);
		v = rdata;
		@(posedge clk_sys);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(10'(v), 10'(e));
	endtask
	task automatic wait_sda(input logic lvl, output int k);
		k = 0;
		while (pin_oe.sda !== lvl) begin
			@(negedge clk_sys);
			k++;
			if (k > 400)
				timeout();
		end
		// return on a rising edge so the next bus cycle starts there
		@(posedge clk_sys);
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		void'($urandom(32'h3F5AF102));
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rchk(OFS_DIV, DIV_RST);
		for (int k = 0; k < 3; k++) begin
			d = 8'($urandom);
			wr(OFS_CTRL, cm[k]);
			wr(OFS_DIV, d);
			if (k == 0)
				ca = d >> 1;
			else if (k == 1)
				ca = (ca & 'hFF) | ((d & 6) << 7);
			else
				ca = (ca & 'h300) | d;
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk(client_addr, 10'(ca));
		end
		n = 3 + $urandom % 4;
		wr(OFS_DIV, 8'(n));
		rchk(OFS_DIV, 8'(n));
		d = 8'($urandom);
		wr(OFS_DBUF, d);
		rchk(OFS_DBUF, d);
		rchk(12'h7FF, 8'h00);
		wr(OFS_CTRL, {4'h0, MODE_SPI_HOST});
		wr(OFS_DBUF, 8'($urandom));
		s = 1'b0;
		repeat (40 * (n + 1)) begin
			@(negedge clk_sys);
			if (sck !== s)
				q.push_back(cyc);
			s = sck;
		end
		chk(10'(q.size()), 10'h010);
		for (int i = 1; i < q.size(); i++)
			chk(10'(q[i] - q[i - 1]), 10'(2 * (n + 1)));
		chk(10'(sck), 10'h000);
		// long count keeps the injected clock pull inside the wait
		wr(OFS_DIV, 8'h0A);
		wr(OFS_CTRL, 8'h08);
		for (int k = 0; k < 3; k++) begin
			wr(OFS_IEN, ien[k]);
			wr(OFS_CTRL, 8'h18);
			wait_sda(1'b1, t);
			@(posedge clk_sys);
			if (k == 1)
				hold_sda <= 1'b1;
			if (k == 2) begin
				repeat (10) @(posedge clk_sys);
				pull_scl <= 1'b1;
				repeat (4) @(posedge clk_sys);
				pull_scl <= 1'b0;
			end
			wait_sda(1'b0, t);
			if (k == 0)
				chk(10'(t >= 22), 10'h001);
			t = 0;
			d = 8'h04;
			while (d[2] !== 1'b0) begin
				rd(OFS_STAT, d);
				t++;
				if (t > 100)
					timeout();
			end
			hold_sda <= 1'b0;
			chk(10'(d[1:0]), k == 0 ? 10'h002 : 10'h001);
			chk(10'(pin_oe), 10'h000);
			rd(OFS_CTRL, d);
			chk(10'(d[4]), 10'h000);
			chk(10'(irq), k == 2 ? 10'h000 : 10'h001);
			wr(OFS_ICLR, 8'h03);
			rd(OFS_STAT, d);
			chk(10'(d[1:0]), 10'h000);
			chk(10'(irq), 10'h000);
		end
		wrap_up();
	end
endmodule // tb

bind ihb_core ihb_chk chk (
	.clk_sys    (clk_sys),
	.rst_n      (rst_n),
	.bus_req    (bus_req),
	.bus_rdata  (bus_rdata),
	.pin_in     (pin_in),
	.pin_out    (pin_out),
	.pin_oe     (pin_oe),
	.sck        (sck),
	.client_addr(client_addr),
	.irq        (irq)
);
